/* hdl/eis_indirect_regs.sv */
// indirect eee global and per-port expansion status register bank
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - The offset register picks the register byte and data moves through the indirect data byte.
// - Each 16-bit register uses two offsets, high byte at the lower offset and low byte next.
// - A read-only 16-bit wakeup error threshold resets to 0x0201.
// - A wake longer than the threshold bumps the wakeup error counter by one.
// - The pcs diagnostic control register is reserved, read-only and reads 0x0001.
// - Expansion status bit 6 always reads 1.
// - Expansion status bit 5 always reads 1, next pages stored in register 8h.
// - Expansion bit 4 latches on a parallel detection fault and clears when read.
// - Expansion bit 3 shows partner next-page ability, reset 0.
// - Expansion bit 2 always reads 1, local next-page ability.
// - Expansion bit 1 latches high when a new page is received, reset 0.
// - Expansion bit 0 shows partner auto-negotiation ability, reset 0.
module eis_indirect_regs #(
    parameter int          NUM_PORTS = 4,
    parameter int          ERR_CNT_W = 16
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    // switch register port
    input  wire logic [7:0]             regAddr,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    input  wire logic [7:0]             regWrData,
    output logic      [7:0]             regRdData,
    // phy status pins, asynchronous to sys_clk
    input  wire logic [NUM_PORTS-1:0]   pdFaultIn,
    input  wire logic [NUM_PORTS-1:0]   pageRxIn,
    input  wire logic [NUM_PORTS-1:0]   partnerNpAbleIn,
    input  wire logic [NUM_PORTS-1:0]   partnerAnAbleIn,
    input  wire logic                   wakeActiveIn,
    // wakeup error statistics
    output logic      [ERR_CNT_W-1:0]   wakeErrCount
);
    logic [7:0]            ctrl_q;
    logic [7:0]            offset_q;
    logic [NUM_PORTS-1:0]  pdMeta_q, pdSync_q, pdPrev_q;
    logic [NUM_PORTS-1:0]  pgMeta_q, pgSync_q, pgPrev_q;
    logic [NUM_PORTS-1:0]  npMeta_q, npSync_q;
    logic [NUM_PORTS-1:0]  anMeta_q, anSync_q;
    logic                  wkMeta_q, wkSync_q;
    logic [NUM_PORTS-1:0]  pdLatch_q;
    logic [NUM_PORTS-1:0]  pgLatch_q;
    logic [NUM_PORTS-1:0]  pdEvent, pgEvent;
    logic [NUM_PORTS-1:0]  expRead;
    logic                  wakeError;
    logic                  selEee, selGlobal, selPort;
    logic [3:0]            portIdx;
    logic [7:0]            dataByte;

    // pick the high or low byte of a 16-bit word by offset parity
    function automatic logic [7:0] pick_byte(input logic [15:0] word, input logic lowByte);
        pick_byte = lowByte ? word[7:0] : word[15:8];
    endfunction

    // expansion status word of one port
    function automatic logic [15:0] exp_word(input logic pd, input logic np, input logic pg, input logic an);
        exp_word = '0;
        exp_word[eis_pkg::EXP_NP_LOC_ABLE] = 1'b1;
        exp_word[eis_pkg::EXP_NP_LOC]      = 1'b1;
        exp_word[eis_pkg::EXP_PD_FAULT]    = pd;
        exp_word[eis_pkg::EXP_PARTNER_NP]  = np;
        exp_word[eis_pkg::EXP_LOCAL_NP]    = 1'b1;
        exp_word[eis_pkg::EXP_PAGE_RX]     = pg;
        exp_word[eis_pkg::EXP_PARTNER_AN]  = an;
    endfunction

    // data-byte writes are dropped on purpose: every indirect register here is read-only
    // control and offset registers written by software
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_q   <= 8'h00;
            offset_q <= 8'h00;
        end else if (regWr) begin
            if (regAddr == eis_pkg::IND_CTRL_ADDR) begin
                ctrl_q <= regWrData;
            end
            if (regAddr == eis_pkg::IND_OFFSET_ADDR) begin
                offset_q <= regWrData;
            end
        end
    end

    // target decode from the control byte
    assign selEee    = ctrl_q[eis_pkg::CTRL_SPACE_MSB:eis_pkg::CTRL_SPACE_LSB] == eis_pkg::SPACE_EEE;
    assign portIdx   = ctrl_q[eis_pkg::CTRL_TARGET_MSB:0];
    assign selGlobal = selEee && portIdx == eis_pkg::TARGET_GLOBAL;
    assign selPort   = selEee && portIdx >= eis_pkg::PORT_FIRST
                       && portIdx <= 4'(NUM_PORTS);

    // two-flop synchronisers on every phy pin
    // only the second flop feeds logic; the first may still be settling
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pdMeta_q <= '0;
            pdSync_q <= '0;
            pgMeta_q <= '0;
            pgSync_q <= '0;
            npMeta_q <= '0;
            npSync_q <= '0;
            anMeta_q <= '0;
            anSync_q <= '0;
            wkMeta_q <= 1'b0;
            wkSync_q <= 1'b0;
        end else begin
            pdMeta_q <= pdFaultIn;
            pdSync_q <= pdMeta_q;
            pgMeta_q <= pageRxIn;
            pgSync_q <= pgMeta_q;
            npMeta_q <= partnerNpAbleIn;
            npSync_q <= npMeta_q;
            anMeta_q <= partnerAnAbleIn;
            anSync_q <= anMeta_q;
            wkMeta_q <= wakeActiveIn;
            wkSync_q <= wkMeta_q;
        end
    end

    // rising-edge detection on the synchronised event pins
    // prev flops reset low like the idle pins, so reset leaves no false event
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pdPrev_q <= '0;
            pgPrev_q <= '0;
        end else begin
            pdPrev_q <= pdSync_q;
            pgPrev_q <= pgSync_q;
        end
    end
    assign pdEvent = pdSync_q & ~pdPrev_q;
    assign pgEvent = pgSync_q & ~pgPrev_q;

    // a data-byte read of either expansion byte counts as reading the register
    always_comb begin
        expRead = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (regRd && regAddr == eis_pkg::IND_DATA_ADDR && selPort
                && portIdx == 4'(p + 1)
                && offset_q[7:1] == eis_pkg::OFS_AN_EXPANSION[7:1]) begin
                expRead[p] = 1'b1;
            end
        end
    end

    // latched-high bits; a new event in the read cycle wins over the clear
    // clearing on either byte means a high-byte read also consumes the events
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pdLatch_q <= '0;
            pgLatch_q <= '0;
        end else begin
            pdLatch_q <= pdEvent | (pdLatch_q & ~expRead);
            pgLatch_q <= pgEvent | (pgLatch_q & ~expRead);
        end
    end

    // wakeup timer against the fixed threshold
    eis_wake_monitor #(
        .CNT_W      (eis_pkg::WAKE_CNT_W)
    ) u_wake (
        .sys_clk    (sys_clk),
        .srst       (srst),
        .wakeActive (wkSync_q),
        .threshold  (eis_pkg::WAKE_THRESH_RST),
        .wakeError  (wakeError)
    );

    // error counter saturates rather than wrapping to a misleading small value
    // one pulse per late wake, however long the wake then lasts
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wakeErrCount <= '0;
        end else if (wakeError && wakeErrCount != {ERR_CNT_W{1'b1}}) begin
            wakeErrCount <= wakeErrCount + 1'b1;
        end
    end

    // indirect data byte contents for the current target and offset
    // other spaces, ports and offsets read as zero
    always_comb begin
        dataByte = 8'h00;
        if (selGlobal) begin
            if (offset_q[7:1] == eis_pkg::OFS_WAKE_THRESH[7:1]) begin
                dataByte = pick_byte(eis_pkg::WAKE_THRESH_RST, offset_q[0]);
            end else if (offset_q[7:1] == eis_pkg::OFS_PCS_DIAG[7:1]) begin
                dataByte = pick_byte(eis_pkg::PCS_DIAG_RST, offset_q[0]);
            end
        end else if (selPort && offset_q[7:1] == eis_pkg::OFS_AN_EXPANSION[7:1]) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (portIdx == 4'(p + 1)) begin
                    dataByte = pick_byte(exp_word(pdLatch_q[p], npSync_q[p], pgLatch_q[p], anSync_q[p]),
                                         offset_q[0]);
                end
            end
        end
    end

    // registered read data, one cycle after the read strobe
    // the byte holds afterwards, so a slow host may sample it late
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            regRdData <= 8'h00;
        end else if (regRd) begin
            case (regAddr)
                eis_pkg::IND_CTRL_ADDR:   regRdData <= ctrl_q;
                eis_pkg::IND_OFFSET_ADDR: regRdData <= offset_q;
                eis_pkg::IND_DATA_ADDR:   regRdData <= dataByte;
                default:                  regRdData <= 8'h00;
            endcase
        end
    end
endmodule // eis_indirect_regs
`default_nettype wire

/* hdl/eis_pkg.sv */
// constants for the indirect eee register bank
package eis_pkg;
    // indirect register addresses on the switch register port
    localparam logic [7:0]  IND_CTRL_ADDR     = 8'h6E;
    localparam logic [7:0]  IND_OFFSET_ADDR   = 8'h6F;
    localparam logic [7:0]  IND_DATA_ADDR     = 8'hA0;
    // control byte fields
    localparam int          CTRL_SPACE_MSB    = 7;
    localparam int          CTRL_SPACE_LSB    = 5;
    localparam int          CTRL_TARGET_MSB   = 3;
    localparam logic [2:0]  SPACE_EEE         = 3'h1;
    localparam logic [3:0]  TARGET_GLOBAL     = 4'h0;
    localparam logic [3:0]  PORT_FIRST        = 4'h1;
    localparam logic [3:0]  PORT_LAST         = 4'h4;
    // byte offsets of the high byte of each 16-bit register
    localparam logic [7:0]  OFS_WAKE_THRESH   = 8'h38;
    localparam logic [7:0]  OFS_PCS_DIAG      = 8'h3A;
    localparam logic [7:0]  OFS_AN_EXPANSION  = 8'h0C;
    // reset and constant values
    localparam logic [15:0] WAKE_THRESH_RST   = 16'h0201;
    localparam logic [15:0] PCS_DIAG_RST      = 16'h0001;
    // expansion status bit positions
    localparam int          EXP_PARTNER_AN    = 0;
    localparam int          EXP_PAGE_RX       = 1;
    localparam int          EXP_LOCAL_NP      = 2;
    localparam int          EXP_PARTNER_NP    = 3;
    localparam int          EXP_PD_FAULT      = 4;
    localparam int          EXP_NP_LOC        = 5;
    localparam int          EXP_NP_LOC_ABLE   = 6;
    // wakeup timer width
    localparam int          WAKE_CNT_W        = 16;
endpackage

/* hdl/eis_wake_monitor.sv */
// single shared wakeup timer that flags a wake taking longer than the threshold
`timescale 1ns/1ps
`default_nettype none
module eis_wake_monitor #(
    parameter int CNT_W = eis_pkg::WAKE_CNT_W
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             srst,
    // wake progress from the phy, already synchronised
    input  wire logic             wakeActive,
    input  wire logic [15:0]      threshold,
    // one-cycle pulse when a wake overruns the threshold
    output logic                  wakeError
);
    logic [CNT_W-1:0] wakeCnt_q;
    logic             flagged_q;

    // count cycles of the current wake; saturate so long wakes never wrap
    always_ff @(posedge sys_clk) begin
        if (srst || !wakeActive) begin
            wakeCnt_q <= '0;
        end else if (wakeCnt_q != {CNT_W{1'b1}}) begin
            wakeCnt_q <= wakeCnt_q + 1'b1;
        end
    end

    // one error per wake, even if the wake stays late for long
    always_ff @(posedge sys_clk) begin
        if (srst || !wakeActive) begin
            flagged_q <= 1'b0;
            wakeError <= 1'b0;
        end else begin
            wakeError <= 1'b0;
            if (!flagged_q && wakeCnt_q > CNT_W'(threshold)) begin
                flagged_q <= 1'b1;
                wakeError <= 1'b1;
            end
        end
    end
endmodule // eis_wake_monitor
`default_nettype wire

/* testbench/eis_host_model.sv */
// behavioural management host on the indirect register port
`timescale 1ns/1ps
`default_nettype none
module eis_host_model (
    // clock
    input  wire logic     sys_clk,
    // register port towards the bank
    output var logic [7:0] regAddr,
    output var logic       regWr,
    output var logic       regRd,
    output var logic [7:0] regWrData
);
    initial begin
        regAddr = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        regWrData = 8'h00;
    end
    // one strobe cycle; released bus shows inverted levels, not stale ones
    task acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        regAddr = a;
        regWr = w;
        regRd = r;
        regWrData = d;
        @(posedge sys_clk);
        #1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask
    // eee space in bits 7:5, target in bits 3:0
    task sel(input logic [3:0] tgt);
        acc(1'b1, 1'b0, eis_pkg::IND_CTRL_ADDR, {eis_pkg::SPACE_EEE, 1'b0, tgt});
    endtask
endmodule // eis_host_model
`default_nettype wire

/* testbench/eis_indirect_regs_properties.sv */
// concurrent checks on the indirect eee register bank ports
`timescale 1ns/1ps
`default_nettype none
module eis_indirect_regs_properties #(
    parameter int NUM_PORTS = 4,
    parameter int ERR_CNT_W = 16
) (
    // clock and reset
    input wire logic                 sys_clk,
    input wire logic                 srst,
    // register port
    input wire logic [7:0]           regAddr,
    input wire logic                 regWr,
    input wire logic                 regRd,
    input wire logic [7:0]           regWrData,
    input wire logic [7:0]           regRdData,
    // phy status and statistics
    input wire logic [NUM_PORTS-1:0] pdFaultIn,
    input wire logic [NUM_PORTS-1:0] pageRxIn,
    input wire logic [NUM_PORTS-1:0] partnerNpAbleIn,
    input wire logic [NUM_PORTS-1:0] partnerAnAbleIn,
    input wire logic                 wakeActiveIn,
    input wire logic [ERR_CNT_W-1:0] wakeErrCount
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic [7:0] ctrl_q;
    logic [7:0] ofs_q;
    logic [7:0] wakeHist_q;
    logic       glbRd;
    logic       portRd;
    // shadow of the stored selection, plus recent wake pin history
    always_ff @(posedge sys_clk) begin
        wakeHist_q <= srst ? 8'h00 : {wakeHist_q[6:0], wakeActiveIn};
        if (srst) begin
            ctrl_q <= 8'h00;
            ofs_q  <= 8'h00;
        end else if (regWr && regAddr == eis_pkg::IND_CTRL_ADDR) begin
            ctrl_q <= regWrData;
        end else if (regWr && regAddr == eis_pkg::IND_OFFSET_ADDR) begin
            ofs_q <= regWrData;
        end
    end
    // data byte reads decoded against the shadow selection
    assign glbRd  = regRd && regAddr == eis_pkg::IND_DATA_ADDR && ctrl_q == 8'h20;
    assign portRd = regRd && regAddr == eis_pkg::IND_DATA_ADDR && ctrl_q[7:4] == 4'h2 &&
                    ctrl_q[3:0] inside {[4'h1:4'h4]};
    chk_thresh_high: assert property (glbRd && ofs_q == 8'h38 |=> regRdData == 8'h02)
        else $error("threshold high byte wrong");
    chk_thresh_low: assert property (glbRd && ofs_q == 8'h39 |=> regRdData == 8'h01)
        else $error("threshold low byte wrong");
    chk_diag_value: assert property (glbRd && ofs_q == 8'h3B |=> regRdData == 8'h01)
        else $error("diagnostic value wrong");
    chk_exp_fixed: assert property (portRd && ofs_q == 8'h0D |=> regRdData[7:5] == 3'h3 && regRdData[2])
        else $error("expansion constant bits wrong");
    chk_exp_upper: assert property (portRd && ofs_q == 8'h0C |=> regRdData == 8'h00)
        else $error("expansion high byte not zero");
    chk_unknown_zero: assert property (regRd && !(regAddr inside {8'h6E, 8'h6F, 8'hA0}) |=> regRdData == 8'h00)
        else $error("unknown address read not zero");
    chk_data_hold: assert property (!regRd |=> $stable(regRdData))
        else $error("read data moved without read");
    chk_ctrl_back: assert property (regRd && regAddr == eis_pkg::IND_CTRL_ADDR |=> regRdData == $past(ctrl_q))
        else $error("control readback wrong");
    chk_err_step: assert property (!$past(srst) && $changed(wakeErrCount) |-> wakeErrCount == $past(wakeErrCount) + 1'b1)
        else $error("error count jumped");
    chk_err_cause: assert property (!$past(srst) && $changed(wakeErrCount) |-> wakeHist_q != 8'h00)
        else $error("error count without wake");
    cover property (glbRd);
    cover property (portRd);
    cover property ($changed(wakeErrCount));
endmodule // eis_indirect_regs_properties
bind eis_indirect_regs eis_indirect_regs_properties #(.NUM_PORTS(NUM_PORTS), .ERR_CNT_W(ERR_CNT_W)) i_chk (
    .sys_clk(sys_clk), .srst(srst), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
    .regWrData(regWrData), .regRdData(regRdData), .pdFaultIn(pdFaultIn), .pageRxIn(pageRxIn),
    .partnerNpAbleIn(partnerNpAbleIn), .partnerAnAbleIn(partnerAnAbleIn),
    .wakeActiveIn(wakeActiveIn), .wakeErrCount(wakeErrCount));
`default_nettype wire

/* testbench/eis_indirect_regs_tb_top.sv */
// self-checking bench for the indirect eee register bank
`timescale 1ns/1ps
`default_nettype none
module eis_indirect_regs_tb_top;
    logic        sys_clk, srst, regWr, regRd, wakeActiveIn, rdSeen;
    logic [7:0]  regAddr, regWrData, regRdData, rnd;
    logic [3:0]  pdFaultIn, pageRxIn, partnerNpAbleIn, partnerAnAbleIn;
    logic [15:0] wakeErrCount;
    logic [7:0]  expQ[$];
    int          failures, samplesChecked;
    eis_host_model i_host (.sys_clk(sys_clk), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
        .regWrData(regWrData));
    eis_indirect_regs i_dut (.sys_clk(sys_clk), .srst(srst), .regAddr(regAddr), .regWr(regWr),
        .regRd(regRd), .regWrData(regWrData), .regRdData(regRdData), .pdFaultIn(pdFaultIn),
        .pageRxIn(pageRxIn), .partnerNpAbleIn(partnerNpAbleIn), .partnerAnAbleIn(partnerAnAbleIn),
        .wakeActiveIn(wakeActiveIn), .wakeErrCount(wakeErrCount));
    // 125 mhz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task end_of_test;
        $display("failures %0d samples_checked %0d", failures, samplesChecked);
        if (failures == 0 && samplesChecked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // note the expectation, then issue the read
    task rdAt(input logic [7:0] a, input logic [7:0] exp);
        expQ.push_back(exp);
        i_host.acc(1'b0, 1'b1, a, 8'h00);
    endtask
    task rd(input logic [7:0] ofs, input logic [7:0] exp);
        i_host.acc(1'b1, 1'b0, eis_pkg::IND_OFFSET_ADDR, ofs);
        rdAt(eis_pkg::IND_DATA_ADDR, exp);
    endtask
    // read data is valid the cycle after the read strobe
    always @(posedge sys_clk) begin
        rdSeen <= regRd;
        if (rdSeen) begin
            check({8'h00, regRdData}, {8'h00, expQ.pop_front()});
        end
    end
    // hang guard, far beyond the planned run
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        end_of_test;
    end
    initial begin
        {failures, samplesChecked} = '0;
        {srst, wakeActiveIn, pdFaultIn, pageRxIn, partnerNpAbleIn, partnerAnAbleIn} = 18'h20000;
        rnd = 8'($urandom(67071));
        repeat (4) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        i_host.sel(eis_pkg::TARGET_GLOBAL);
        rd(8'h38, 8'h02);
        rd(8'h39, 8'h01);
        rd(8'h3A, 8'h00);
        rd(8'h3B, 8'h01);
        i_host.acc(1'b1, 1'b0, eis_pkg::IND_DATA_ADDR, rnd);
        rd(8'h39, 8'h01);
        // a space other than eee hides the global registers
        i_host.acc(1'b1, 1'b0, eis_pkg::IND_CTRL_ADDR, 8'h40);
        rd(8'h38, 8'h00);
        // random partner ability levels on every port
        rnd = 8'($urandom);
        partnerAnAbleIn = rnd[3:0];
        partnerNpAbleIn = rnd[7:4];
        for (int p = 1; p <= 4; p++) begin
            i_host.sel(4'(p));
            rd(8'h0C, 8'h00);
            rd(8'h0D, {3'h3, 1'b0, rnd[p+3], 2'h2, rnd[p-1]});
            pdFaultIn[p-1] = 1'b1;
            pageRxIn[p-1] = 1'b1;
            repeat (6) @(posedge sys_clk);
            #1;
            {pdFaultIn, pageRxIn} = 8'h00;
            rd(8'h0D, {3'h3, 1'b1, rnd[p+3], 2'h3, rnd[p-1]});
            rd(8'h0D, {3'h3, 1'b0, rnd[p+3], 2'h2, rnd[p-1]});
            // page event timed to land on the clearing read's edge must survive it
            pageRxIn[p-1] = 1'b1;
            @(posedge sys_clk);
            rdAt(eis_pkg::IND_DATA_ADDR, {3'h3, 1'b0, rnd[p+3], 2'h2, rnd[p-1]});
            pageRxIn = 4'h0;
            rd(8'h0D, {3'h3, 1'b0, rnd[p+3], 2'h3, rnd[p-1]});
        end
        i_host.sel(4'h5);
        rd(8'h0D, 8'h00);
        rdAt(eis_pkg::IND_CTRL_ADDR, 8'h25);
        rdAt(eis_pkg::IND_OFFSET_ADDR, 8'h0D);
        rdAt(8'h55, 8'h00);
        // a long wake counts once, a short one not at all
        wakeActiveIn = 1'b1;
        repeat (eis_pkg::WAKE_THRESH_RST + 20) @(posedge sys_clk);
        #1;
        wakeActiveIn = 1'b0;
        repeat (8) @(posedge sys_clk);
        check(wakeErrCount, 16'h0001);
        wakeActiveIn = 1'b1;
        repeat (eis_pkg::WAKE_THRESH_RST - 20) @(posedge sys_clk);
        #1;
        wakeActiveIn = 1'b0;
        repeat (8) @(posedge sys_clk);
        check(wakeErrCount, 16'h0001);
        end_of_test;
    end
endmodule // eis_indirect_regs_tb_top
`default_nettype wire
